// File: hdl/pinc_decode.sv
// opcode decoder for the port-input-and-increment instruction
`timescale 1ns/10ps
`default_nettype none
`include "pinc_params.svh"

module pinc_decode (
  input  wire logic [15:0]       word0,
  input  wire logic [15:0]       word1,
  output var  pinc_pkg::pinc_dec_t dec
);
  import pinc_pkg::*;

  // purely combinational field split and legality check
  always_comb begin
    dec.is_word = word0[8];
    dec.special = word0[0];
    dec.src     = word0[7:4];
    dec.dst     = word1[7:4];
    dec.cnt     = word1[11:8];
    // zero source or destination field selects other opcodes
    dec.legal   = (word0[15:9] == `PINC_OP_HI) &&
                  (word0[3:1] == `PINC_W0_LOW_FIXED) &&
                  (word0[7:4] != 4'h0) &&
                  (word1[15:12] == `PINC_W1_HI_FIXED) &&
                  (word1[7:4] != 4'h0) &&
                  (word1[3:0] == `PINC_W1_LOW_FIXED);
  end

endmodule // pinc_decode
`default_nettype wire

// File: hdl/pinc_exec.sv
// port-input-and-increment executor with its register file
// Overview of operation
// - read port addressed by source register
// - write captured value at destination pointer
// - port address is full sixteen bits
// - advance pointer one (byte) or two (word)
// - decrement counter register by one, unless it is also the pointer offset register
// - V set if count zero; C,S,D,H kept
// - pointer is word, or pair when segmented
// - special variants use special i/o space
// - opcode S bit picks i/o space
// - source register left unchanged unless it is also pointer or counter
`timescale 1ns/10ps
`default_nettype none
`include "pinc_params.svh"

module pinc_exec (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // register port
  input  wire logic [`PINC_ADDR_W-1:0]  reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [15:0]              reg_rdata,
  // instruction issue
  input  wire logic                     instr_valid,
  input  wire logic [15:0]              instr_word0,
  input  wire logic [15:0]              instr_word1,
  output logic                          busy,
  output logic                          done,
  output logic                          priv_trap,
  output logic                          illegal,
  // i/o read side
  output var  pinc_pkg::pinc_io_req_t   io_out,
  input  wire logic                     io_ack,
  input  wire logic [15:0]              io_rdata,
  // memory write side
  output var  pinc_pkg::pinc_mem_req_t  mem_out,
  input  wire logic                     mem_ack
);
  import pinc_pkg::*;

  logic [15:0]            gpr_q [16];   // general registers
  logic [15:0]            ctrl_q;       // mode bits and flags
  pinc_state_t            state_q;      // executor state
  pinc_dec_t              dec;          // live decode of issue words
  pinc_dec_t              op_q;         // latched decode
  logic [`PINC_CYC_W-1:0] cyc_q;        // cycles since issue
  logic [15:0]            cap_q;        // captured port value
  logic [15:0]            ptr_new;      // advanced pointer offset
  logic [15:0]            cnt_new;      // decremented counter
  logic [3:0]             ptr_idx;      // register holding offset
  logic                   upd;          // register update strobe
  logic                   issue;        // accepted instruction

  // offset word of the pointer: pair low half when segmented
  function automatic logic [3:0] off_idx(input logic [3:0] d, input logic seg);
    off_idx = seg ? (d | 4'h1) : d;
  endfunction

  pinc_decode u_dec (
    .word0 (instr_word0),
    .word1 (instr_word1),
    .dec   (dec)
  );

  assign issue   = instr_valid && (state_q == PINC_IDLE);
  assign upd     = (state_q == PINC_UPD);
  assign ptr_idx = off_idx(op_q.dst, ctrl_q[`PINC_BIT_SEG]);
  // step by element size
  assign ptr_new = gpr_q[ptr_idx] + (op_q.is_word ? 16'h0002 : 16'h0001);
  assign cnt_new = gpr_q[op_q.cnt] - 16'h0001;

  // sequencer: io read, memory write, update, pad to fixed time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= PINC_IDLE;
    end else begin
      unique case (state_q)
        PINC_IDLE: begin
          // refuse illegal or unprivileged issue without transfer
          if (issue && dec.legal && ctrl_q[`PINC_BIT_SYS]) begin
            state_q <= PINC_IO;
          end
        end
        PINC_IO: begin
          if (io_ack) begin
            state_q <= PINC_MEM;
          end
        end
        PINC_MEM: begin
          if (mem_ack) begin
            state_q <= PINC_UPD;
          end
        end
        PINC_UPD: begin
          state_q <= PINC_PAD;
        end
        PINC_PAD: begin
          // slow bus stretches past the nominal time
          if (cyc_q >= `PINC_CYC_W'(`PINC_EXEC_CYCLES - 1)) begin
            state_q <= PINC_IDLE;
          end
        end
      endcase
    end
  end

  // latch decode and count cycles from issue
  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_q  <= '0;
      cyc_q <= '0;
    end else if (issue) begin
      op_q  <= dec;
      cyc_q <= `PINC_CYC_W'(1);
    end else if (state_q != PINC_IDLE && cyc_q != '1) begin
      cyc_q <= cyc_q + `PINC_CYC_W'(1);
    end
  end

  // status pulses and busy level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      priv_trap <= 1'b0;
      illegal   <= 1'b0;
    end else begin
      illegal   <= issue && !dec.legal;
      priv_trap <= issue && dec.legal && !ctrl_q[`PINC_BIT_SYS];
      done      <= (state_q == PINC_PAD) && (cyc_q >= `PINC_CYC_W'(`PINC_EXEC_CYCLES - 1));
      if (issue && dec.legal && ctrl_q[`PINC_BIT_SYS]) begin
        busy <= 1'b1;
      end else if (state_q == PINC_PAD && cyc_q >= `PINC_CYC_W'(`PINC_EXEC_CYCLES - 1)) begin
        busy <= 1'b0;
      end
    end
  end

  // i/o input cycle, held until acknowledged
  always_ff @(posedge core_clk) begin
    if (rst) begin
      io_out <= '0;
      cap_q  <= '0;
    end else if (issue && dec.legal && ctrl_q[`PINC_BIT_SYS]) begin
      io_out.req     <= 1'b1;
      io_out.special <= dec.special;
      io_out.is_word <= dec.is_word;
      io_out.addr    <= gpr_q[dec.src];
    end else if (state_q == PINC_IO && io_ack) begin
      io_out.req <= 1'b0;
      // byte lands in low lane, upper lane zero
      cap_q      <= op_q.is_word ? io_rdata : {8'h00, io_rdata[7:0]};
    end
  end

  // memory write of the captured value
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_out <= '0;
    end else if (state_q == PINC_IO && io_ack) begin
      mem_out.req     <= 1'b1;
      mem_out.is_word <= op_q.is_word;
      mem_out.data    <= op_q.is_word ? io_rdata : {8'h00, io_rdata[7:0]};
      // segment word first, offset second in segmented mode
      if (ctrl_q[`PINC_BIT_SEG]) begin
        mem_out.addr <= {gpr_q[op_q.dst & 4'he], gpr_q[op_q.dst | 4'h1]};
      end else begin
        mem_out.addr <= {16'h0000, gpr_q[op_q.dst]};
      end
    end else if (state_q == PINC_MEM && mem_ack) begin
      mem_out.req <= 1'b0;
    end
  end

  // general registers; executor update beats a same-cycle software write
  generate
    for (genvar i = 0; i < 16; i++) begin : g_gpr
      always_ff @(posedge core_clk) begin
        if (rst) begin
          gpr_q[i] <= 16'h0000;
        end else if (upd && ptr_idx == 4'(i)) begin
          gpr_q[i] <= ptr_new;
        end else if (upd && op_q.cnt == 4'(i)) begin
          gpr_q[i] <= cnt_new;
        end else if (reg_wr && reg_addr == 5'(i)) begin
          // source register is an update target only if it doubles as pointer or counter
          gpr_q[i] <= reg_wdata;
        end
      end
    end
  endgenerate

  // mode and flag word; only V moves, Z left as it was
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= `PINC_CTRL_RESET;
    end else if (upd) begin
      ctrl_q[`PINC_BIT_V] <= (cnt_new == 16'h0000);
    end else if (reg_wr && reg_addr == `PINC_IDX_CTRL) begin
      ctrl_q <= reg_wdata;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr <= `PINC_GPR_LAST) begin
        reg_rdata <= gpr_q[reg_addr[3:0]];
      end else if (reg_addr == `PINC_IDX_CTRL) begin
        reg_rdata <= ctrl_q;
      end else if (reg_addr == `PINC_IDX_STAT) begin
        reg_rdata <= {13'h0000, state_q};
      end else begin
        reg_rdata <= 16'h0000;                         // unmapped reads zero
      end
    end
  end

endmodule // pinc_exec
`default_nettype wire

// File: hdl/pinc_params.svh
// constants for the port-input-and-increment executor
`ifndef PINC_PARAMS_SVH
`define PINC_PARAMS_SVH

// register port map, word indices
`define PINC_ADDR_W        5
`define PINC_GPR_LAST      5'h0f
`define PINC_IDX_CTRL      5'h10
`define PINC_IDX_STAT      5'h11

// control/flag word field positions
`define PINC_BIT_SEG       15
`define PINC_BIT_SYS       14
`define PINC_BIT_C         7
`define PINC_BIT_Z         6
`define PINC_BIT_S         5
`define PINC_BIT_V         4
`define PINC_BIT_D         3
`define PINC_BIT_H         2
`define PINC_CTRL_RESET    16'h4000

// opcode fields
`define PINC_OP_HI         7'h1d
`define PINC_W0_LOW_FIXED  3'h0
`define PINC_W1_HI_FIXED   4'h0
`define PINC_W1_LOW_FIXED  4'h8

// timing
`define PINC_EXEC_CYCLES   21
`define PINC_CYC_W         5

`endif

// File: hdl/pinc_pkg.sv
// types shared by the port-input-and-increment executor
package pinc_pkg;

  // decoded instruction
  typedef struct packed {
    logic       legal;   // encoding matches
    logic       is_word; // word variant
    logic       special; // special i/o space
    logic [3:0] src;     // port_address_reg index
    logic [3:0] dst;     // destination pointer index
    logic [3:0] cnt;     // counter register index
  } pinc_dec_t;

  // i/o read request toward the bus
  typedef struct packed {
    logic        req;
    logic        special;
    logic        is_word;
    logic [15:0] addr;
  } pinc_io_req_t;

  // memory write request toward the bus
  typedef struct packed {
    logic        req;
    logic        is_word;
    logic [31:0] addr;
    logic [15:0] data;
  } pinc_mem_req_t;

  // executor states
  typedef enum logic [2:0] {
    PINC_IDLE = 3'b000,
    PINC_IO   = 3'b001,
    PINC_MEM  = 3'b010,
    PINC_UPD  = 3'b011,
    PINC_PAD  = 3'b100
  } pinc_state_t;

endpackage

// File: sim/pinc_bus_model.sv
// far-side model: port answers and memory stores
`timescale 1ns/10ps
`default_nettype none
module pinc_bus_model (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic [3:0]             dly,
  input  var  pinc_pkg::pinc_io_req_t  io_out,
  input  var  pinc_pkg::pinc_mem_req_t mem_out,
  output logic                        io_ack,
  output logic [15:0]                 io_rdata,
  output logic                        mem_ack,
  output logic [47:0]                 last_wr
);
  import pinc_pkg::*;
  logic [3:0] wait_q; // cycles a request has waited
  logic       go;     // answer this cycle
  assign go = wait_q >= dly;
  // stall counter, cleared on each answer
  always_ff @(posedge core_clk) begin
    if (rst || io_ack || mem_ack || !(io_out.req || mem_out.req)) wait_q <= 4'h0;
    else wait_q <= wait_q + 4'h1;
  end
  // port data is the address scrambled; it churns when idle so stale reads show
  always_ff @(posedge core_clk) begin
    io_ack <= !rst && io_out.req && !io_ack && go;
    io_rdata <= rst ? 16'h0000 : (io_out.req && go) ? io_out.addr ^ 16'h5a5a : ~io_rdata;
    mem_ack <= !rst && mem_out.req && !mem_ack && go;
    if (mem_out.req && !mem_ack && go) last_wr <= {mem_out.addr, mem_out.data};
  end
endmodule // pinc_bus_model
`default_nettype wire

// File: sim/pinc_exec_assertions.sv
// port checker for the port-input executor
`timescale 1ns/10ps
`default_nettype none
`include "pinc_params.svh"
module pinc_exec_assertions (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               instr_valid,
  input wire logic [15:0]        instr_word0,
  input wire logic [15:0]        instr_word1,
  input wire logic               busy,
  input wire logic               done,
  input wire logic               priv_trap,
  input wire logic               illegal,
  input var  pinc_pkg::pinc_io_req_t  io_out,
  input wire logic               io_ack,
  input wire logic [15:0]        io_rdata,
  input var  pinc_pkg::pinc_mem_req_t mem_out,
  input wire logic               mem_ack
);
  import pinc_pkg::*;
  // encoding shape, judged from the issue words alone
  wire logic legal;
  assign legal = instr_word0[15:9] == `PINC_OP_HI && instr_word0[7:4] != 4'h0
    && instr_word0[3:1] == `PINC_W0_LOW_FIXED && instr_word1[15:12] == `PINC_W1_HI_FIXED
    && instr_word1[7:4] != 4'h0 && instr_word1[3:0] == `PINC_W1_LOW_FIXED;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_issue; instr_valid && !busy && legal; endsequence
  sequence s_io_take; io_out.req && io_ack; endsequence
  // mode trap or a read in the space the s bit picks
  property p_start; s_issue |=> priv_trap || (busy && io_out.req
    && io_out.special == $past(instr_word0[0]) && io_out.is_word == $past(instr_word0[8])); endproperty
  property p_bad; instr_valid && !busy && !legal |=> illegal && !busy && !io_out.req; endproperty
  property p_trap; priv_trap |-> !busy && !io_out.req && !mem_out.req; endproperty
  property p_io_hold; io_out.req && !io_ack |=> io_out.req && $stable(io_out.addr); endproperty
  property p_mem_data; s_io_take |=> mem_out.req && !io_out.req && mem_out.data ==
    ($past(io_out.is_word) ? $past(io_rdata) : {8'h00, $past(io_rdata[7:0])}); endproperty
  property p_mem_cause; $rose(mem_out.req) |-> $past(io_ack); endproperty
  property p_mem_hold; mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr); endproperty
  // busy falls with done, after a full run of cycles
  property p_len; done |-> !busy && $past(busy) && $past(busy, 20); endproperty
  property p_ignore; instr_valid && busy |=> !illegal && !priv_trap; endproperty
  a_start: assert property (p_start) else $error("wrong start of read");
  a_bad: assert property (p_bad) else $error("bad words not flagged");
  a_trap: assert property (p_trap) else $error("transfer after trap");
  a_io_hold: assert property (p_io_hold) else $error("port address moved");
  a_mem_data: assert property (p_mem_data) else $error("wrong store data");
  a_mem_cause: assert property (p_mem_cause) else $error("store without read");
  a_mem_hold: assert property (p_mem_hold) else $error("store address moved");
  a_len: assert property (p_len) else $error("run length wrong");
  a_ignore: assert property (p_ignore) else $error("issue while busy taken");
endmodule // pinc_exec_assertions
`default_nettype wire

// File: sim/pinc_exec_bench.sv
// self-checking bench for the port-input executor
`timescale 1ns/10ps
`default_nettype none
module pinc_exec_bench;
  import pinc_pkg::*;
  logic          core_clk = 1'b0;
  logic          rst = 1'b1;
  logic [4:0]    reg_addr = 5'h00;
  logic [15:0]   reg_wdata = 16'h0000;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [15:0]   reg_rdata;
  logic          instr_valid = 1'b0;
  logic [15:0]   instr_word0 = 16'h0000;
  logic [15:0]   instr_word1 = 16'h0000;
  logic          busy, done, priv_trap, illegal, io_ack, mem_ack;
  pinc_io_req_t  io_out;
  pinc_mem_req_t mem_out;
  logic [15:0]   io_rdata;
  logic [3:0]    dly = 4'h0;
  logic [47:0]   last_wr;
  int            miscompares = 0;
  int            checks_done = 0;
  always #2.5 core_clk = ~core_clk;
  pinc_exec i_pinc_exec (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .instr_valid, .instr_word0, .instr_word1, .busy, .done, .priv_trap, .illegal,
    .io_out, .io_ack, .io_rdata, .mem_out, .mem_ack);
  pinc_bus_model i_pinc_bus_model (.core_clk, .rst, .dly, .io_out, .mem_out, .io_ack,
    .io_rdata, .mem_ack, .last_wr);
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // masked read; data stands from the cycle after the strobe until the next read strobe
  task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk({32'h0, reg_rdata & m}, {32'h0, e});
  endtask
  // ev: 0 done, 1 trap, 2 bad words; an ev 0 issue is repeated once while busy
  task automatic issue(input logic [15:0] w0, input logic [15:0] w1, input logic [1:0] ev);
    int n;
    n = 0;
    @(posedge core_clk);
    instr_word0 <= w0; instr_word1 <= w1; instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= (ev == 2'h0);
    #1;
    while (!(done || priv_trap || illegal) && n < 200) begin
      @(posedge core_clk);
      instr_valid <= 1'b0;
      #1 n++;
    end
    chk({45'h0, done, priv_trap, illegal}, {45'h0, 3'h4 >> ev});
  endtask
  task automatic results;
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #5000 miscompares++;
    results();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    // byte read, normal space, flags c s d h preset; v preset so a clear shows
    wr(5'h10, 16'h40bc);
    wr(5'h04, 16'h4000);
    wr(5'h06, 16'h0229);
    wr(5'h00, 16'h0016);
    issue(16'h3a60, 16'h0048, 2'h0);
    chk(last_wr, {32'h0000_4000, 16'h0073});
    rd(5'h04, 16'hffff, 16'h4001);
    rd(5'h00, 16'hffff, 16'h0015);
    rd(5'h06, 16'hffff, 16'h0229);
    rd(5'h10, 16'hffbf, 16'h40ac);
    // word read, special space, segmented pair, slow far side, offset wraps
    wr(5'h10, 16'hc0ac);
    wr(5'h04, 16'h0012);
    wr(5'h05, 16'hfffe);
    wr(5'h06, 16'h8421);
    wr(5'h00, 16'h0001);
    dly <= 4'h3;
    issue(16'h3b61, 16'h0048, 2'h0);
    chk(last_wr, {32'h0012_fffe, 16'hde7b});
    rd(5'h05, 16'hffff, 16'h0000);
    rd(5'h04, 16'hffff, 16'h0012);
    rd(5'h00, 16'hffff, 16'h0000);
    rd(5'h10, 16'hffbf, 16'hc0bc);
    // normal mode traps and moves nothing
    wr(5'h10, 16'h0000);
    issue(16'h3a60, 16'h0048, 2'h1);
    chk(last_wr, {32'h0012_fffe, 16'hde7b});
    rd(5'h04, 16'hffff, 16'h0012);
    issue(16'h3a68, 16'h0048, 2'h2);
    rd(5'h1f, 16'hffff, 16'h0000);
    results();
  end
endmodule // pinc_exec_bench
bind pinc_exec pinc_exec_assertions i_pinc_exec_assertions (.core_clk, .rst, .instr_valid,
  .instr_word0, .instr_word1, .busy, .done, .priv_trap, .illegal, .io_out, .io_ack,
  .io_rdata, .mem_out, .mem_ack);
`default_nettype wire
